// ===== hdl/prbc_ctrl.sv
// top: control registers, rx gating, false carrier report, loopback and led select
`timescale 1ns/1ps
module prbc_ctrl
  import prbc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // management register port
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // straps
  input wire logic coder_bypass_strap,
  input wire logic scrambler_bypass_strap,
  input wire logic alignment_bypass_strap,
  // status from the datapath
  input wire logic carrier_integrity_monitor,
  input wire logic tx_activity,
  input wire logic full_duplex,
  input wire logic polarity_rev,
  input wire logic speed_100,
  input wire logic false_carrier,
  // receive from line side
  input wire logic line_rx_dv,
  input wire logic line_rx_er,
  input wire logic [4:0] line_rxd,
  // mii transmit from mac
  input wire logic mii_tx_en,
  input wire logic [3:0] mii_txd,
  // mii receive to mac
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic [4:0] mii_rxd,
  // transmit toward line
  output logic line_tx_en,
  output logic [3:0] line_txd,
  // control outputs
  output logic indicator_one_pin,
  output logic indicator_four_pin,
  output logic coder_bypass,
  output logic scrambler_bypass,
  output logic align_bypass,
  output logic manchester_coder_loop,
  output logic fiber_driver_strength,
  output logic pmd_loop,
  output logic digital_reset
);
  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic rs1_r, rs2_r; // rs1_r feeds only rs2_r
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital reset pulse, counts itself out
  logic [2:0] drst_cnt_r; // nonzero while digital reset runs
  logic drst_go; // write of one to the reset bit
  logic compat; // compatibility mode
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      drst_cnt_r <= 3'h0;
    end
    else if (drst_go)
    begin
      drst_cnt_r <= 3'(PRBC_DRST_CYC);
    end
    else if (drst_cnt_r != 3'h0)
    begin
      drst_cnt_r <= drst_cnt_r - 3'h1;
    end
  end
  // soft reset feeds registers synchronously, keeping async reset constant-only
  logic srst;
  assign srst = (drst_cnt_r != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: first clocked cycle after any reset
  logic strap_load_r; // high one cycle after release / soft reset
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      strap_load_r <= 1'b1;
    end
    else
    begin
      strap_load_r <= srst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] cfg_r, lbe_r, tcfg_r;
  logic wr_cfg, wr_lbe, wr_tcfg;
  assign wr_cfg = reg_wr && (reg_addr == PRBC_ADDR_CFG);
  assign wr_lbe = reg_wr && (reg_addr == PRBC_ADDR_LBE);
  assign wr_tcfg = reg_wr && (reg_addr == PRBC_ADDR_TCFG);
  assign compat = tcfg_r[PRBC_TCFG_COMPAT];
  assign drst_go = wr_cfg && reg_wdata[PRBC_CFG_DRST] && !compat && !srst;

  // config register; reset bit reads one while reset runs
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      cfg_r <= PRBC_CFG_RST;
    end
    else if (srst)
    begin
      cfg_r <= PRBC_CFG_RST;
    end
    else if (wr_cfg)
    begin
      cfg_r[PRBC_CFG_IND1] <= reg_wdata[PRBC_CFG_IND1];
      cfg_r[PRBC_CFG_IND4] <= reg_wdata[PRBC_CFG_IND4];
      if (!compat)
      begin
        cfg_r[PRBC_CFG_RXDIS] <= reg_wdata[PRBC_CFG_RXDIS];
      end
    end
  end

  // loopback register; strap bits load after reset
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      lbe_r <= PRBC_LBE_RST;
    end
    else if (srst)
    begin
      lbe_r <= PRBC_LBE_RST;
    end
    else if (strap_load_r)
    begin
      lbe_r[PRBC_LBE_BPCODE] <= coder_bypass_strap;
      lbe_r[PRBC_LBE_BPSCRM] <= scrambler_bypass_strap;
      lbe_r[PRBC_LBE_BPALN] <= alignment_bypass_strap;
    end
    else if (wr_lbe)
    begin
      lbe_r[15:8] <= reg_wdata[15:8];
    end
  end

  // 1Ch holds only the compatibility bit here
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      tcfg_r <= PRBC_TCFG_RST;
    end
    else if (srst)
    begin
      tcfg_r <= PRBC_TCFG_RST;
    end
    else if (wr_tcfg)
    begin
      tcfg_r[PRBC_TCFG_COMPAT] <= reg_wdata[PRBC_TCFG_COMPAT];
    end
  end

  // read mux, registered; unmapped reads zero
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      reg_rdata <= 16'h0000;
    end
    else
    begin
      unique case (reg_addr)
        PRBC_ADDR_CFG: reg_rdata <= {cfg_r[15:1], srst};
        PRBC_ADDR_LBE: reg_rdata <= lbe_r;
        PRBC_ADDR_TCFG: reg_rdata <= tcfg_r;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive gate
  logic gate_open;
  logic rx_dis_eff;
  assign rx_dis_eff = cfg_r[PRBC_CFG_RXDIS] && !compat;
  prbc_rx_gate u_gate (
    .clk(clk),
    .rst_n(rs2_r),
    .disable_req(rx_dis_eff),
    .pkt_active(line_rx_dv),
    .gate_open(gate_open)
  );

  ////////////////////////////////////////////////////////////////////////////
  // loopback selection
  logic rloop_eff, ploop_eff;
  assign rloop_eff = lbe_r[PRBC_LBE_RLOOP] && !lbe_r[PRBC_LBE_PLOOP];
  assign ploop_eff = lbe_r[PRBC_LBE_PLOOP] && !lbe_r[PRBC_LBE_RLOOP];

  // mii receive path: gating and false carrier codes
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      mii_rx_dv <= 1'b0;
      mii_rx_er <= 1'b0;
      mii_rxd <= 5'h00;
    end
    else if (!gate_open || srst)
    begin
      // link logic untouched; only the mac sees silence
      mii_rx_dv <= 1'b0;
      mii_rx_er <= 1'b0;
      mii_rxd <= 5'h00;
    end
    else if (false_carrier && lbe_r[PRBC_LBE_BADSSD] && !lbe_r[PRBC_LBE_BPALN])
    begin
      mii_rx_dv <= 1'b0;
      if (lbe_r[PRBC_LBE_BPCODE])
      begin
        mii_rx_er <= 1'b0;
        mii_rxd <= PRBC_FC_SYM;
      end
      else
      begin
        mii_rx_er <= 1'b1;
        mii_rxd <= {1'b0, PRBC_FC_NIB};
      end
    end
    else
    begin
      mii_rx_dv <= line_rx_dv;
      mii_rx_er <= line_rx_er;
      mii_rxd <= line_rxd;
    end
  end

  // transmit path: remote loopback echoes line data
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      line_tx_en <= 1'b0;
      line_txd <= 4'h0;
    end
    else if (rloop_eff)
    begin
      line_tx_en <= line_rx_dv;
      line_txd <= line_rxd[3:0];
    end
    else
    begin
      line_tx_en <= mii_tx_en && !srst;
      line_txd <= mii_txd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // leds and control outputs
  always_ff @(posedge clk or negedge rs2_r)
  begin
    if (!rs2_r)
    begin
      indicator_one_pin <= 1'b0;
      indicator_four_pin <= 1'b0;
      coder_bypass <= 1'b0;
      scrambler_bypass <= 1'b0;
      align_bypass <= 1'b0;
      manchester_coder_loop <= 1'b0;
      fiber_driver_strength <= 1'b0;
      pmd_loop <= 1'b0;
      digital_reset <= 1'b0;
    end
    else
    begin
      indicator_one_pin <= cfg_r[PRBC_CFG_IND1] ? carrier_integrity_monitor
                                                : tx_activity;
      indicator_four_pin <= (cfg_r[PRBC_CFG_IND4] || speed_100) ? full_duplex
                                                                : polarity_rev;
      coder_bypass <= lbe_r[PRBC_LBE_BPCODE];
      scrambler_bypass <= lbe_r[PRBC_LBE_BPSCRM];
      align_bypass <= lbe_r[PRBC_LBE_BPALN];
      manchester_coder_loop <= lbe_r[PRBC_LBE_MLOOP];
      fiber_driver_strength <= lbe_r[PRBC_LBE_FXDRV];
      pmd_loop <= ploop_eff;
      digital_reset <= srst;
    end
  end
endmodule

// ===== pkg/prbc_pkg.sv
// package: register offsets, bit positions, reset values and codes for the rx gate / loopback control
//
// What this block does
// - rx disable blocks packets, link stays up
// - disable mid-packet: finish packet, then block
// - enable mid-packet: stay blocked until packet ends
// - compatibility mode ignores rx-disable and reset writes
// - indicator one: integrity monitor or tx activity
// - indicator four: duplex, or polarity at 10
// - digital reset restores the 17h, 18h and 1Ch registers; rx disable clears, so the rx gate reopens once no packet is in flight
// - false carrier: rx_er high, dv low, 1110
// - coder bypass: dv low, five-bit 11110
// - alignment bypass: never report false carrier
// - bit 14 bypasses coder, reset from strap
// - bit 13 bypasses scrambler, reset from strap
// - bit 12 bypasses alignment path, strap reset
// - bit 11 loops manchester coder output back
// - bit 10 picks fiber driver load strength
// - remote loopback echoes line data, ignores tx
// - both loopbacks set: enter neither
// - bit 8 medium loopback feeds scrambled data back
package prbc_pkg;
  localparam logic [4:0] PRBC_ADDR_CFG = 5'h17;
  localparam logic [4:0] PRBC_ADDR_LBE = 5'h18;
  localparam logic [4:0] PRBC_ADDR_TCFG = 5'h1C;
  // config register fields
  localparam int PRBC_CFG_RXDIS = 3;
  localparam int PRBC_CFG_IND1 = 2;
  localparam int PRBC_CFG_IND4 = 1;
  localparam int PRBC_CFG_DRST = 0;
  // loopback / bypass register fields
  localparam int PRBC_LBE_BADSSD = 15;
  localparam int PRBC_LBE_BPCODE = 14;
  localparam int PRBC_LBE_BPSCRM = 13;
  localparam int PRBC_LBE_BPALN = 12;
  localparam int PRBC_LBE_MLOOP = 11;
  localparam int PRBC_LBE_FXDRV = 10;
  localparam int PRBC_LBE_RLOOP = 9;
  localparam int PRBC_LBE_PLOOP = 8;
  // compatibility-mode bit position inside 1Ch
  localparam int PRBC_TCFG_COMPAT = 13;
  localparam logic [15:0] PRBC_CFG_RST = 16'h0000;
  localparam logic [15:0] PRBC_LBE_RST = 16'h8000;
  localparam logic [15:0] PRBC_TCFG_RST = 16'h0000;
  // false carrier codes on the receive bus
  localparam logic [3:0] PRBC_FC_NIB = 4'hE;
  localparam logic [4:0] PRBC_FC_SYM = 5'h1E;
  // cycles the internal digital reset is held
  localparam int PRBC_DRST_CYC = 4;
endpackage

// ===== hdl/prbc_rx_gate.sv
// rx gate: packet-boundary gating of receive data toward the mac
`timescale 1ns/1ps
module prbc_rx_gate
  import prbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic disable_req,
  input wire logic pkt_active,
  output logic gate_open
);
  // gate state only moves while no packet is in flight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_open <= 1'b1;
    end
    else if (!pkt_active)
    begin
      gate_open <= !disable_req;
    end
  end
endmodule

// ===== tb/prbc_ctrl_chk.sv
// checker: port-level assertions for the rx gate / loopback control
`timescale 1ns/1ps
module prbc_ctrl_chk
  import prbc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic line_rx_dv,
  input wire logic [4:0] line_rxd,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_er,
  input wire logic [4:0] mii_rxd,
  input wire logic indicator_four_pin,
  input wire logic align_bypass,
  input wire logic manchester_coder_loop,
  input wire logic fiber_driver_strength,
  input wire logic pmd_loop,
  input wire logic digital_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  dreset_len_a: assert property (
    $rose(digital_reset) |-> digital_reset[*4] ##1 !digital_reset)
    else $error("digital reset width wrong");
  dreset_clear_a: assert property (
    $fell(digital_reset) |-> !manchester_coder_loop && !fiber_driver_strength && !pmd_loop)
    else $error("controls not cleared by digital reset");
  fc_code_a: assert property (
    mii_rx_er && !mii_rx_dv |-> mii_rxd[3:0] == PRBC_FC_NIB)
    else $error("false carrier code wrong");
  align_nofc_a: assert property (
    align_bypass && $past(align_bypass) |-> !(mii_rx_er && !mii_rx_dv))
    else $error("false carrier seen in alignment bypass");
  // the mac may only see frames cut at the line's own boundaries
  gate_fall_a: assert property (
    $fell(mii_rx_dv) |-> !$past(line_rx_dv))
    else $error("frame truncated toward mac");
  gate_rise_a: assert property (
    $rose(mii_rx_dv) |-> !$past(line_rx_dv, 2))
    else $error("frame started mid packet");
  rx_data_a: assert property (
    mii_rx_dv |-> mii_rxd == $past(line_rxd))
    else $error("receive data not passed");
  led_four_a: assert property (
    speed_100 && $stable(speed_100) && $stable(full_duplex) |-> indicator_four_pin == full_duplex)
    else $error("indicator four not duplex at 100");
endmodule

// ===== tb/prbc_mac_model.sv
// mac model: counts received beats and sends a fixed transmit nibble
`timescale 1ns/1ps
module prbc_mac_model
(
  input wire logic clk,
  input wire logic send,
  input wire logic rx_dv,
  output int rx_cnt,
  output logic tx_en,
  output logic [3:0] txd
);
  initial rx_cnt = 0;
  initial tx_en = 0;
  initial txd = 4'h0;
  // idle txd toggles, so after a send it alternates between hA and the data nibble h5
  always @(posedge clk)
  begin
    rx_cnt <= rx_cnt + int'(rx_dv === 1'b1);
    tx_en <= #1 send;
    txd <= #1 send ? 4'h5 : ~txd;
  end
endmodule

// ===== tb/prbc_ctrl_bench.sv
// bench: registers, rx gating, false carrier, leds, loopback, digital reset
`timescale 1ns/1ps
module prbc_ctrl_bench
  import prbc_pkg::*;
;
  logic clk, nrst, reg_wr, coder_bypass_strap, scrambler_bypass_strap, alignment_bypass_strap;
  logic carrier_integrity_monitor, tx_activity, full_duplex, polarity_rev, speed_100;
  logic false_carrier, line_rx_dv, line_rx_er, mii_tx_en, mii_rx_dv, mii_rx_er, line_tx_en;
  logic indicator_one_pin, indicator_four_pin, coder_bypass, scrambler_bypass, align_bypass;
  logic manchester_coder_loop, fiber_driver_strength, pmd_loop, digital_reset, send;
  logic [4:0] reg_addr, line_rxd, mii_rxd;
  logic [3:0] mii_txd, line_txd;
  logic [15:0] reg_wdata, reg_rdata;
  int bad_count = 0;
  int cmp_count = 0;
  int rx_cnt;
  prbc_ctrl uut (.clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .coder_bypass_strap, .scrambler_bypass_strap, .alignment_bypass_strap,
    .carrier_integrity_monitor, .tx_activity, .full_duplex, .polarity_rev, .speed_100,
    .false_carrier, .line_rx_dv, .line_rx_er, .line_rxd, .mii_tx_en, .mii_txd,
    .mii_rx_dv, .mii_rx_er, .mii_rxd, .line_tx_en, .line_txd, .indicator_one_pin,
    .indicator_four_pin, .coder_bypass, .scrambler_bypass, .align_bypass,
    .manchester_coder_loop, .fiber_driver_strength, .pmd_loop, .digital_reset);
  prbc_mac_model mac (.clk, .send, .rx_dv(mii_rx_dv), .rx_cnt, .tx_en(mii_tx_en),
    .txd(mii_txd));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobe rests for one edge so two writes never touch reg_wr in one step
  task automatic wr(logic [4:0] a, logic [15:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 0;
    tick(1);
  endtask
  task automatic rd(logic [4:0] a, logic [15:0] e);
    reg_addr = a;
    tick(2);
    chk("reg_rdata", e, reg_rdata);
  endtask
  function automatic logic [15:0] outs();
    return 16'({coder_bypass, scrambler_bypass, align_bypass, manchester_coder_loop,
      fiber_driver_strength, pmd_loop});
  endfunction
  // receive side toward the mac: error, valid, five data bits
  function automatic logic [15:0] rxo();
    return 16'({mii_rx_er, mii_rx_dv, mii_rxd});
  endfunction
  // one line-side packet of n beats; optional config write at beat w
  task automatic pkt(int n, int w, logic [15:0] d, int e);
    int c0;
    c0 = rx_cnt;
    for (int i = 0; i < n + 2; i++)
    begin
      line_rx_dv = (i < n);
      line_rxd = 5'(i);
      reg_wr = (i == w);
      reg_addr = PRBC_ADDR_CFG;
      reg_wdata = d;
      tick(1);
    end
    chk("rx beats", 16'(e), 16'(rx_cnt - c0));
  endtask
  task automatic close_out();
    $display("counts: %0d compared, %0d unexpected", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] ra[4] = '{5'h17, 5'h18, 5'h1C, 5'h05};
  logic [15:0] re[4] = '{16'h0000, 16'hC000, 16'h0000, 16'h0000};
  logic [15:0] lw[4] = '{16'h0C7F, 16'h0300, 16'h0100, 16'h7000};
  logic [15:0] lr[4] = '{16'h0C00, 16'h0300, 16'h0100, 16'h7000};
  logic [15:0] lo[4] = '{16'h0006, 16'h0000, 16'h0001, 16'h0038};
  logic [15:0] fw[3] = '{16'h8000, 16'hC000, 16'h9000};
  logic [15:0] fe[3] = '{16'h004E, 16'h001E, 16'h0000};
  logic [15:0] fm[3] = '{16'h007F, 16'h007F, 16'h0060};
  logic [15:0] gw[3] = '{16'h0000, 16'h0006, 16'h0000};
  logic [2:0] gs[3] = '{3'b010, 3'b001, 3'b110};
  logic [15:0] ge[3] = '{16'h0003, 16'h0001, 16'h0002};
  initial
  begin
    {nrst, reg_wr, reg_addr, reg_wdata, send, false_carrier} = '0;
    {line_rx_dv, line_rx_er, line_rxd, carrier_integrity_monitor, full_duplex} = '0;
    {scrambler_bypass_strap, alignment_bypass_strap, speed_100} = '0;
    {coder_bypass_strap, tx_activity, polarity_rev} = 3'b111;
    tick(4);
    nrst = 1;
    tick(4);
    foreach (ra[i]) rd(ra[i], re[i]);
    chk("bypass outs", 16'h0020, outs());
    foreach (lw[i])
    begin
      wr(PRBC_ADDR_LBE, lw[i]);
      rd(PRBC_ADDR_LBE, lr[i]);
      chk("control outs", lo[i], outs());
    end
    $display("end of register test");
    foreach (fw[i])
    begin
      wr(PRBC_ADDR_LBE, fw[i]);
      false_carrier = 1;
      tick(2);
      chk("false carrier", fe[i], rxo() & fm[i]);
      false_carrier = 0;
      tick(1);
    end
    wr(PRBC_ADDR_LBE, 16'h8000);
    $display("end of false carrier test");
    pkt(6, -1, 16'h0000, 6);
    pkt(8, 3, 16'h0008, 8);
    pkt(5, -1, 16'h0000, 0);
    pkt(8, 3, 16'h0000, 0);
    pkt(4, -1, 16'h0000, 4);
    // disable first, then compatibility: the stored disable must go inert
    wr(PRBC_ADDR_CFG, 16'h0008);
    wr(PRBC_ADDR_TCFG, 16'h2000);
    wr(PRBC_ADDR_CFG, 16'h0001);
    rd(PRBC_ADDR_CFG, 16'h0008);
    chk("digital_reset", 16'h0000, 16'(digital_reset));
    pkt(4, -1, 16'h0000, 4);
    wr(PRBC_ADDR_TCFG, 16'h0000);
    $display("end of gating test");
    foreach (gw[i])
    begin
      {speed_100, polarity_rev, full_duplex} = gs[i];
      wr(PRBC_ADDR_CFG, gw[i]);
      tick(2);
      chk("ind pins", ge[i], 16'({indicator_one_pin, indicator_four_pin}));
    end
    {speed_100, full_duplex} = 2'b00;
    $display("end of indicator test");
    wr(PRBC_ADDR_LBE, 16'h0200);
    {send, line_rx_dv, line_rxd} = {2'b11, 5'h0A};
    tick(2);
    chk("remote loop", 16'h006A, 16'({line_tx_en, mii_rx_dv, mii_rxd}));
    chk("line tx", 16'h001A, 16'({line_tx_en, line_txd}));
    line_rx_dv = 0;
    // both loopbacks requested: the mac transmit path must win again
    wr(PRBC_ADDR_LBE, 16'h0300);
    tick(2);
    chk("both loops", 16'h0015, 16'({line_tx_en, line_txd}));
    send = 0;
    $display("end of loopback test");
    wr(PRBC_ADDR_LBE, 16'h0C00);
    wr(PRBC_ADDR_CFG, 16'h0007);
    tick(2);
    chk("digital_reset", 16'h0001, 16'(digital_reset));
    tick(6);
    rd(PRBC_ADDR_LBE, 16'hC000);
    chk("digital_reset", 16'h0000, 16'(digital_reset));
    rd(PRBC_ADDR_CFG, 16'h0000);
    $display("end of digital reset test");
    close_out();
  end
  // hang guard: the whole sequence needs well under 400 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
bind prbc_ctrl prbc_ctrl_chk u_chk (.clk, .nrst, .speed_100, .full_duplex, .line_rx_dv,
  .line_rxd, .mii_rx_dv, .mii_rx_er, .mii_rxd, .indicator_four_pin, .align_bypass,
  .manchester_coder_loop, .fiber_driver_strength, .pmd_loop, .digital_reset);
